// [verilog/debug_and_boundary_scan_port.v]
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defs.vh"
// Function
// - select low at reset gives emulator access to processor state
// - select high at reset gives boundary-scan pin access
// - mode latched at chip reset; later select changes ignored until reset
// - boundary mode decodes sample, extest and bypass
// - emulator idcode returns the processor's own identity word
// - boundary register is 186 cells long
// - each pin owns adjacent input, output and control cells
// - output cell value drives the pad during extest
// - input cell captures the pad level
// - control cell chooses pad drive or input
// - groups descend from bit 185, input then output then control
// - halt mode injects store-multiple, exports registers through chain
// - communication chain moves words with monitor program, core running
// - three internal chains chosen through the emulator port
// - channel tx and rx flags become interrupt requests
// - control bit blocks system access through the emulator port
// - read-only 32-bit identity register
// - serial port served by two transfer channel requests
module debug_and_boundary_scan_port #(
  parameter [31:0] CHIP_ID_VALUE = 32'h0123_4567,
  parameter [31:0] CPU_ID_VALUE = 32'h0abc_de01
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire ce_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output wire tdo_o,
  output wire tdo_oe_o,
  input wire scan_vs_emulator_select_i,
  input wire factory_mode_pin_i,
  input wire chip_reset_pin_n_i,
  input wire [`PIN_GROUPS-1:0] pad_in_i,
  output wire [`PIN_GROUPS-1:0] pad_out_o,
  output wire [`PIN_GROUPS-1:0] pad_oe_o,
  output wire [`PIN_GROUPS-1:0] core_pad_in_o,
  input wire [`PIN_GROUPS-1:0] core_out_i,
  input wire [`PIN_GROUPS-1:0] core_oe_i,
  input wire core_halted_i,
  input wire [31:0] halt_export_data_i,
  output wire store_multiple_injection_o,
  output wire core_restart_o,
  output wire [31:0] debug_cfg_o,
  output wire debug_channel_tx_flag_o,
  output wire debug_channel_rx_flag_o,
  output wire tx_irq_o,
  output wire rx_irq_o,
  input wire serial_rx_ready_i,
  input wire serial_tx_empty_i,
  output wire xfer_rx_req_o,
  output wire xfer_tx_req_o,
  output wire boundary_mode_o,
  input wire [`ADDR_W-1:0] addr_i,
  input wire [31:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output wire [31:0] rd_data_o
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [`SYNC_W-1:0] sync_w;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire sel_s;
  wire fact_s;
  wire chip_reset_pin_n_s;
  wire [`PIN_GROUPS-1:0] pad_s;
  bit_sync u_sync (
    .clk_i(clk_sys_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .async_i({pad_in_i, chip_reset_pin_n_i, factory_mode_pin_i,
      scan_vs_emulator_select_i, tdi_i, tms_i, tck_i}),
    .sync_o(sync_w)
  );
  assign tck_s = sync_w[0];
  assign tms_s = sync_w[1];
  assign tdi_s = sync_w[2];
  assign sel_s = sync_w[3];
  assign fact_s = sync_w[4];
  assign chip_reset_pin_n_s = sync_w[5];
  assign pad_s = sync_w[`SYNC_W-1:6];
  assign core_pad_in_o = pad_s;
  // ****************************************
  // mode latch
  // ****************************************
  reg mode_ff;
  reg mode_pend_ff;
  reg tck_d_ff;
  wire chip_rst;
  wire tck_rise;
  wire tck_fall;
  wire step;
  assign chip_rst = ~chip_reset_pin_n_s;
  // sampled edges: tck must stay well below clk_sys_i / 4
  assign tck_rise = tck_s & ~tck_d_ff;
  assign tck_fall = ~tck_s & tck_d_ff;
  // tap held still until the mode has been taken
  assign step = ce_i & tck_rise & ~mode_pend_ff & ~chip_rst;
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_ff <= 1'b0;
      mode_pend_ff <= 1'b1;
      tck_d_ff <= 1'b0;
    end else if (ce_i) begin
      tck_d_ff <= tck_s;
      if (chip_rst) begin
        mode_pend_ff <= 1'b1;
      end else if (mode_pend_ff) begin
        mode_ff <= sel_s;
        mode_pend_ff <= 1'b0;
      end
    end
  end
  assign boundary_mode_o = mode_ff;
  // ****************************************
  // tap and instruction decode
  // ****************************************
  wire [3:0] tap_state;
  tap_fsm u_tap (
    .clk_i(clk_sys_i),
    .reset_i(reset_i | chip_rst),
    .step_i(step),
    .tms_i(tms_s),
    .state_o(tap_state)
  );
  reg [`CTRL_W-1:0] ctrl_ff;
  reg [`IR_LEN-1:0] ir_ff;
  reg [`IR_LEN-1:0] ir_sr_ff;
  // shared decode for capture, shift, update and tdo
  function [1:0] dr_pick;
    input [`IR_LEN-1:0] ir;
    input bmode;
    input blocked;
    begin
      if (bmode) begin
        if (ir == `IR_EXTEST || ir == `IR_SAMPLE) begin
          dr_pick = `DR_BSR;
        end else begin
          dr_pick = `DR_BYP;
        end
      end else if (ir == `IR_IDCODE) begin
        dr_pick = `DR_WORD;
      end else if (blocked) begin
        dr_pick = `DR_BYP;
      end else if (ir == `IR_SCAN_N) begin
        dr_pick = `DR_SEL;
      end else if (ir == `IR_INTEST) begin
        dr_pick = `DR_WORD;
      end else begin
        dr_pick = `DR_BYP;
      end
    end
  endfunction
  wire [1:0] dr_sel;
  wire blocked;
  assign blocked = ctrl_ff[`CTRL_BLOCK];
  assign dr_sel = dr_pick(ir_ff, mode_ff, blocked);
  wire cap_dr = step & (tap_state == `TS_CAP_DR);
  wire sh_dr = step & (tap_state == `TS_SH_DR);
  wire upd_dr = step & (tap_state == `TS_UPD_DR);
  wire intest_word = ~mode_ff & ~blocked & (ir_ff == `IR_INTEST);
  // ****************************************
  // shift registers
  // ****************************************
  reg [`BSR_LEN-1:0] bsr_sr_ff;
  reg [`BSR_LEN-1:0] bsr_upd_ff;
  reg [`CHAIN_W-1:0] word_sr_ff;
  reg [`SEL_W-1:0] sel_sr_ff;
  reg [1:0] chain_ff;
  reg byp_ff;
  reg tdo_ff;
  reg tdo_oe_ff;
  reg [31:0] comm_tx_ff;
  reg [31:0] comm_rx_ff;
  reg [31:0] cfg_ff;
  reg tx_flag_ff;
  reg rx_flag_ff;
  reg inject_ff;
  reg restart_ff;
  wire [`BSR_LEN-1:0] bsr_cap;
  genvar g;
  generate
    for (g = 0; g < `PIN_GROUPS; g = g + 1) begin : grp
      // group 0 holds bits 185..183, descending from there
      localparam integer BASE = 3 * (`PIN_GROUPS - 1 - g);
      assign bsr_cap[BASE + `CELL_IN] = pad_s[g];
      assign bsr_cap[BASE + `CELL_OUT] = core_out_i[g];
      assign bsr_cap[BASE + `CELL_CTL] = core_oe_i[g];
    end
  endgenerate
  always @(posedge clk_sys_i) begin
    if (reset_i | chip_rst) begin
      ir_ff <= `IR_BYPASS;
      ir_sr_ff <= `IR_CAPTURE;
      bsr_sr_ff <= {`BSR_LEN{1'b0}};
      bsr_upd_ff <= {`BSR_LEN{1'b0}};
      word_sr_ff <= `ZERO32;
      sel_sr_ff <= {`SEL_W{1'b0}};
      chain_ff <= `CHAIN_HALT;
      byp_ff <= 1'b0;
      cfg_ff <= `ZERO32;
      inject_ff <= 1'b0;
      restart_ff <= 1'b0;
    end else if (ce_i) begin
      inject_ff <= 1'b0;
      restart_ff <= 1'b0;
      if (step) begin
        case (tap_state)
          `TS_RESET: begin
            ir_ff <= mode_ff ? `IR_BYPASS : `IR_IDCODE;
          end
          `TS_CAP_IR: begin
            ir_sr_ff <= `IR_CAPTURE;
          end
          `TS_SH_IR: begin
            ir_sr_ff <= {tdi_s, ir_sr_ff[`IR_LEN-1:1]};
          end
          `TS_UPD_IR: begin
            ir_ff <= ir_sr_ff;
          end
          default: begin
          end
        endcase
      end
      if (step && tap_state == `TS_IDLE && !mode_ff && !blocked &&
          ir_ff == `IR_RESTART) begin
        restart_ff <= 1'b1;
      end
      if (cap_dr) begin
        case (dr_sel)
          `DR_BSR: bsr_sr_ff <= bsr_cap;
          `DR_SEL: sel_sr_ff <= {2'h0, chain_ff};
          `DR_WORD: begin
            if (ir_ff == `IR_IDCODE) begin
              word_sr_ff <= CPU_ID_VALUE;
            end else if (chain_ff == `CHAIN_HALT) begin
              word_sr_ff <= halt_export_data_i;
            end else if (chain_ff == `CHAIN_COMM) begin
              word_sr_ff <= comm_tx_ff;
            end else begin
              word_sr_ff <= cfg_ff;
            end
          end
          default: byp_ff <= 1'b0;
        endcase
      end
      if (sh_dr) begin
        case (dr_sel)
          `DR_BSR: bsr_sr_ff <= {tdi_s, bsr_sr_ff[`BSR_LEN-1:1]};
          `DR_SEL: sel_sr_ff <= {tdi_s, sel_sr_ff[`SEL_W-1:1]};
          `DR_WORD: word_sr_ff <= {tdi_s, word_sr_ff[`CHAIN_W-1:1]};
          default: byp_ff <= tdi_s;
        endcase
      end
      if (upd_dr) begin
        if (dr_sel == `DR_BSR) begin
          bsr_upd_ff <= bsr_sr_ff;
        end
        if (dr_sel == `DR_SEL && sel_sr_ff[1:0] != 2'h3) begin
          chain_ff <= sel_sr_ff[1:0];
        end
        if (intest_word && chain_ff == `CHAIN_HALT && core_halted_i) begin
          inject_ff <= 1'b1;
        end
        if (intest_word && chain_ff == `CHAIN_CFG) begin
          cfg_ff <= word_sr_ff;
        end
      end
    end
  end
  // ****************************************
  // tdo on the falling edge
  // ****************************************
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (ce_i && tck_fall) begin
      tdo_oe_ff <= (tap_state == `TS_SH_DR) || (tap_state == `TS_SH_IR);
      if (tap_state == `TS_SH_IR) begin
        tdo_ff <= ir_sr_ff[0];
      end else begin
        case (dr_sel)
          `DR_BSR: tdo_ff <= bsr_sr_ff[0];
          `DR_SEL: tdo_ff <= sel_sr_ff[0];
          `DR_WORD: tdo_ff <= word_sr_ff[0];
          default: tdo_ff <= byp_ff;
        endcase
      end
    end
  end
  assign tdo_o = tdo_ff;
  assign tdo_oe_o = tdo_oe_ff;
  // ****************************************
  // pad drive
  // ****************************************
  reg [`PIN_GROUPS-1:0] pad_out_ff;
  reg [`PIN_GROUPS-1:0] pad_oe_ff;
  wire extest_on;
  assign extest_on = mode_ff & (ir_ff == `IR_EXTEST);
  generate
    for (g = 0; g < `PIN_GROUPS; g = g + 1) begin : drv
      localparam integer BASE = 3 * (`PIN_GROUPS - 1 - g);
      always @(posedge clk_sys_i) begin
        if (reset_i) begin
          pad_out_ff[g] <= 1'b0;
          pad_oe_ff[g] <= 1'b0;
        end else if (ce_i) begin
          pad_out_ff[g] <= extest_on ? bsr_upd_ff[BASE + `CELL_OUT] : core_out_i[g];
          pad_oe_ff[g] <= extest_on ? bsr_upd_ff[BASE + `CELL_CTL] : core_oe_i[g];
        end
      end
    end
  endgenerate
  assign pad_out_o = pad_out_ff;
  assign pad_oe_o = pad_oe_ff;
  // ****************************************
  // register port and channel flags
  // ****************************************
  reg [31:0] rd_data_ff;
  reg tx_irq_ff;
  reg rx_irq_ff;
  reg xfer_rx_ff;
  reg xfer_tx_ff;
  wire comm_sel;
  wire dbg_took_tx;
  wire dbg_gave_rx;
  wire sw_wr_tx;
  wire sw_rd_rx;
  wire [31:0] status_w;
  assign comm_sel = intest_word & (chain_ff == `CHAIN_COMM);
  assign dbg_took_tx = cap_dr & comm_sel;
  assign dbg_gave_rx = upd_dr & comm_sel;
  assign sw_wr_tx = wr_i & (addr_i == `A_COMM_TX);
  assign sw_rd_rx = rd_i & (addr_i == `A_COMM_RX);
  assign status_w = {26'h0, core_halted_i, fact_s, (sel_s ^ mode_ff), mode_ff,
    rx_flag_ff, tx_flag_ff};
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      ctrl_ff <= `CTRL_RST;
      comm_tx_ff <= `ZERO32;
      comm_rx_ff <= `ZERO32;
      tx_flag_ff <= 1'b0;
      rx_flag_ff <= 1'b0;
      rd_data_ff <= `ZERO32;
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
      xfer_rx_ff <= 1'b0;
      xfer_tx_ff <= 1'b0;
    end else if (ce_i) begin
      if (wr_i && addr_i == `A_CTRL) begin
        ctrl_ff <= wr_data_i[`CTRL_W-1:0];
      end
      if (sw_wr_tx) begin
        comm_tx_ff <= wr_data_i;
      end
      // the setting party wins a same-cycle clear
      if (sw_wr_tx) begin
        tx_flag_ff <= 1'b1;
      end else if (dbg_took_tx) begin
        tx_flag_ff <= 1'b0;
      end
      if (dbg_gave_rx) begin
        comm_rx_ff <= word_sr_ff;
        rx_flag_ff <= 1'b1;
      end else if (sw_rd_rx) begin
        rx_flag_ff <= 1'b0;
      end
      // tx interrupt asks for a word when the channel is free
      tx_irq_ff <= ~tx_flag_ff & ctrl_ff[`CTRL_TX_IE];
      rx_irq_ff <= rx_flag_ff & ctrl_ff[`CTRL_RX_IE];
      xfer_rx_ff <= serial_rx_ready_i & ctrl_ff[`CTRL_XFER_EN];
      xfer_tx_ff <= serial_tx_empty_i & ctrl_ff[`CTRL_XFER_EN];
      if (rd_i) begin
        case (addr_i)
          `A_CHIP_ID: rd_data_ff <= CHIP_ID_VALUE;
          `A_CTRL: rd_data_ff <= {28'h0, ctrl_ff};
          `A_STATUS: rd_data_ff <= status_w;
          `A_COMM_TX: rd_data_ff <= comm_tx_ff;
          `A_COMM_RX: rd_data_ff <= comm_rx_ff;
          default: rd_data_ff <= `ZERO32;
        endcase
      end else begin
        rd_data_ff <= `ZERO32;
      end
    end
  end
  assign rd_data_o = rd_data_ff;
  assign tx_irq_o = tx_irq_ff;
  assign rx_irq_o = rx_irq_ff;
  assign xfer_rx_req_o = xfer_rx_ff;
  assign xfer_tx_req_o = xfer_tx_ff;
  assign debug_channel_tx_flag_o = tx_flag_ff;
  assign debug_channel_rx_flag_o = rx_flag_ff;
  assign store_multiple_injection_o = inject_ff;
  assign core_restart_o = restart_ff;
  assign debug_cfg_o = cfg_ff;
endmodule
`default_nettype wire

// [verilog/scan_port_defs.vh]
`ifndef SCAN_PORT_DEFS_VH
`define SCAN_PORT_DEFS_VH
// ****************************************
// chain geometry
// ****************************************
`define BSR_LEN 186
`define PIN_GROUPS 62
`define CELL_IN 2
`define CELL_OUT 1
`define CELL_CTL 0
`define CHAIN_W 32
`define SEL_W 4
`define SYNC_W 68
// ****************************************
// instruction codes
// ****************************************
`define IR_LEN 4
`define IR_CAPTURE 4'h1
`define IR_EXTEST 4'h0
`define IR_SAMPLE 4'h1
`define IR_SCAN_N 4'h2
`define IR_RESTART 4'h4
`define IR_INTEST 4'hc
`define IR_IDCODE 4'he
`define IR_BYPASS 4'hf
// ****************************************
// data register selection and chains
// ****************************************
`define DR_BYP 2'h0
`define DR_BSR 2'h1
`define DR_SEL 2'h2
`define DR_WORD 2'h3
`define CHAIN_HALT 2'h0
`define CHAIN_COMM 2'h1
`define CHAIN_CFG 2'h2
// ****************************************
// tap states
// ****************************************
`define TS_RESET 4'h0
`define TS_IDLE 4'h1
`define TS_SEL_DR 4'h2
`define TS_CAP_DR 4'h3
`define TS_SH_DR 4'h4
`define TS_EX1_DR 4'h5
`define TS_PAU_DR 4'h6
`define TS_EX2_DR 4'h7
`define TS_UPD_DR 4'h8
`define TS_SEL_IR 4'h9
`define TS_CAP_IR 4'ha
`define TS_SH_IR 4'hb
`define TS_EX1_IR 4'hc
`define TS_PAU_IR 4'hd
`define TS_EX2_IR 4'he
`define TS_UPD_IR 4'hf
// ****************************************
// register port
// ****************************************
`define ADDR_W 5
`define A_CHIP_ID 5'h00
`define A_CTRL 5'h04
`define A_STATUS 5'h08
`define A_COMM_TX 5'h0c
`define A_COMM_RX 5'h10
`define CTRL_W 4
`define CTRL_RST 4'h0
`define CTRL_BLOCK 0
`define CTRL_TX_IE 1
`define CTRL_RX_IE 2
`define CTRL_XFER_EN 3
`define ST_TX 0
`define ST_RX 1
`define ST_MODE 2
`define ST_MISMATCH 3
`define ST_FACTORY 4
`define ST_HALTED 5
`define ZERO32 32'h0000_0000
`endif

// [verilog/bit_sync.v]
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defs.vh"
module bit_sync (
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  input wire [`SYNC_W-1:0] async_i,
  output wire [`SYNC_W-1:0] sync_o
);
  reg [`SYNC_W-1:0] meta_ff;
  reg [`SYNC_W-1:0] stable_ff;
  // first stage feeds only the second
  always @(posedge clk_i) begin
    if (reset_i) begin
      meta_ff <= {`SYNC_W{1'b0}};
      stable_ff <= {`SYNC_W{1'b0}};
    end else if (ce_i) begin
      meta_ff <= async_i;
      stable_ff <= meta_ff;
    end
  end
  assign sync_o = stable_ff;
endmodule
`default_nettype wire

// [verilog/tap_fsm.v]
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defs.vh"
module tap_fsm (
  input wire clk_i,
  input wire reset_i,
  input wire step_i,
  input wire tms_i,
  output wire [3:0] state_o
);
  localparam [3:0] S_RESET = `TS_RESET;
  localparam [3:0] S_IDLE = `TS_IDLE;
  localparam [3:0] S_SEL_DR = `TS_SEL_DR;
  localparam [3:0] S_CAP_DR = `TS_CAP_DR;
  localparam [3:0] S_SH_DR = `TS_SH_DR;
  localparam [3:0] S_EX1_DR = `TS_EX1_DR;
  localparam [3:0] S_PAU_DR = `TS_PAU_DR;
  localparam [3:0] S_EX2_DR = `TS_EX2_DR;
  localparam [3:0] S_UPD_DR = `TS_UPD_DR;
  localparam [3:0] S_SEL_IR = `TS_SEL_IR;
  localparam [3:0] S_CAP_IR = `TS_CAP_IR;
  localparam [3:0] S_SH_IR = `TS_SH_IR;
  localparam [3:0] S_EX1_IR = `TS_EX1_IR;
  localparam [3:0] S_PAU_IR = `TS_PAU_IR;
  localparam [3:0] S_EX2_IR = `TS_EX2_IR;
  localparam [3:0] S_UPD_IR = `TS_UPD_IR;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  always @* begin
    case (state_ff)
      S_RESET: nxt_state = tms_i ? S_RESET : S_IDLE;
      S_IDLE: nxt_state = tms_i ? S_SEL_DR : S_IDLE;
      S_SEL_DR: nxt_state = tms_i ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: nxt_state = tms_i ? S_EX1_DR : S_SH_DR;
      S_SH_DR: nxt_state = tms_i ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: nxt_state = tms_i ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: nxt_state = tms_i ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: nxt_state = tms_i ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: nxt_state = tms_i ? S_SEL_DR : S_IDLE;
      S_SEL_IR: nxt_state = tms_i ? S_RESET : S_CAP_IR;
      S_CAP_IR: nxt_state = tms_i ? S_EX1_IR : S_SH_IR;
      S_SH_IR: nxt_state = tms_i ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: nxt_state = tms_i ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: nxt_state = tms_i ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: nxt_state = tms_i ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: nxt_state = tms_i ? S_SEL_DR : S_IDLE;
      default: nxt_state = S_RESET;
    endcase
  end
  // advances only on a sampled tck rise
  always @(posedge clk_i) begin
    if (reset_i) begin
      state_ff <= S_RESET;
    end else if (step_i) begin
      state_ff <= nxt_state;
    end
  end
  assign state_o = state_ff;
endmodule
`default_nettype wire

// [dv/scan_port_properties.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defs.vh"
module scan_port_checker #(
  parameter [31:0] CHIP_ID_VALUE = 32'h0000_0000
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic tck_i,
  input wire logic tdo_o,
  input wire logic chip_reset_pin_n_i,
  input wire logic core_halted_i,
  input wire logic store_multiple_injection_o,
  input wire logic [31:0] debug_cfg_o,
  input wire logic debug_channel_tx_flag_o,
  input wire logic debug_channel_rx_flag_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o,
  input wire logic serial_rx_ready_i,
  input wire logic xfer_rx_req_o,
  input wire logic boundary_mode_o,
  input wire logic [`ADDR_W-1:0] addr_i,
  input wire logic rd_i,
  input wire logic [31:0] rd_data_o
);
  // ****************************************
  // cycles since any reset, saturating
  // ****************************************
  logic [3:0] quiet_ff;
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || !chip_reset_pin_n_i) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hf) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_id_read; rd_i && (addr_i == `A_CHIP_ID); endsequence
  sequence s_one_shot; store_multiple_injection_o ##1 !store_multiple_injection_o; endsequence
  property p_id_read; s_id_read |=> rd_data_o == CHIP_ID_VALUE; endproperty
  property p_rd_idle; !$past(rd_i) |-> rd_data_o == 32'h0000_0000; endproperty
  property p_tx_irq; tx_irq_o |-> !$past(debug_channel_tx_flag_o); endproperty
  property p_rx_irq; rx_irq_o |-> $past(debug_channel_rx_flag_o); endproperty
  property p_xfer_rx; xfer_rx_req_o |-> $past(serial_rx_ready_i); endproperty
  // tdo may only move a few cycles after a tck fall
  property p_tdo_fall; $changed(tdo_o) |-> !$past(tck_i, 2); endproperty
  property p_mode_hold; $changed(boundary_mode_o) |-> quiet_ff < 4'hc; endproperty
  property p_inject;
    store_multiple_injection_o |-> $past(core_halted_i) && !boundary_mode_o ##0 s_one_shot;
  endproperty
  property p_cfg_emul; $changed(debug_cfg_o) |-> !boundary_mode_o; endproperty
  a_id_read: assert property (p_id_read) else $error("id read wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_tx_irq: assert property (p_tx_irq) else $error("tx irq wrong");
  a_rx_irq: assert property (p_rx_irq) else $error("rx irq wrong");
  a_xfer_rx: assert property (p_xfer_rx) else $error("rx transfer request wrong");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off tck fall");
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed on the fly");
  a_inject: assert property (p_inject) else $error("injection wrong");
  a_cfg_emul: assert property (p_cfg_emul) else $error("cfg moved in boundary mode");
endmodule
bind debug_and_boundary_scan_port scan_port_checker #(.CHIP_ID_VALUE(CHIP_ID_VALUE)) u_chk (.*);
`default_nettype wire

// [dv/jtag_probe.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// debugger pod, tck idles low between frames
// ****************************************
module jtag_probe (
  output var logic tck_o,
  output var logic tms_o,
  output var logic tdi_o,
  input wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // tdo read just before the rise, long after the fall
  task automatic cyc(input logic ms, input logic di, output logic dout);
    tms_o = ms;
    tdi_o = di;
    #31;
    dout = tdo_i;
    tck_o = 1'b1;
    #62.5;
    tck_o = 1'b0;
    #31.5;
  endtask
  task automatic tap_reset();
    logic d;
    repeat (5) cyc(1'b1, 1'b0, d);
    cyc(1'b0, 1'b0, d);
  endtask
  // lsb first; starts and ends in run-test-idle
  task automatic scan(input logic ir, input int n, input logic [191:0] din,
                      output logic [191:0] dout);
    logic d;
    dout = '0;
    cyc(1'b1, 1'b0, d);
    if (ir) cyc(1'b1, 1'b0, d);
    cyc(1'b0, 1'b0, d);
    cyc(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) begin
      cyc(i == n - 1, din[i], d);
      dout[i] = d;
    end
    cyc(1'b1, ~din[n - 1], d);
    cyc(1'b0, din[n - 1], d);
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scan_port_defs.vh"
module tb;
  localparam logic [31:0] CHIP_ID = 32'h5a3c_0f01; // arbitrary
  localparam logic [31:0] CPU_ID = 32'h1e2d_3c4b; // arbitrary
  localparam logic [31:0] HALT_W = 32'h8421_7bde;
  localparam logic [31:0] TX_W = 32'h7e81_4c2a;
  localparam logic [`PIN_GROUPS-1:0] PAD = 62'h2a5a_c3f0_0ff0_1e2d;
  localparam logic [`PIN_GROUPS-1:0] COUT = 62'h1234_5678_9abc_def0;
  localparam logic [`PIN_GROUPS-1:0] COE = 62'h0f0f_0f0f_0f0f_0f0f;
  localparam logic [`PIN_GROUPS-1:0] XA = 62'h3c3c_a5a5_5a5a_c3c3;
  localparam logic [`PIN_GROUPS-1:0] XB = 62'h1111_2222_4444_8888;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, scan_vs_emulator_select_i = 1'b0;
  logic factory_mode_pin_i = 1'b0, chip_reset_pin_n_i = 1'b1, core_halted_i = 1'b0;
  logic serial_rx_ready_i = 1'b1, serial_tx_empty_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [31:0] halt_export_data_i = HALT_W, wr_data_i = '0, w;
  logic [31:0] wc [3] = '{32'h1357_9bdf, 32'h2468_ace0, 32'h0f1e_2d3c};
  logic [`ADDR_W-1:0] addr_i = '0;
  logic [`PIN_GROUPS-1:0] core_out_i = COUT, core_oe_i = COE;
  logic [191:0] v, d, e;
  logic [7:0] inject_cnt = 8'h00, restart_cnt = 8'h00;
  int bad_count = 0, checks = 0;
  wire tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, store_multiple_injection_o, core_restart_o;
  wire debug_channel_tx_flag_o, debug_channel_rx_flag_o, tx_irq_o, rx_irq_o;
  wire xfer_rx_req_o, xfer_tx_req_o, boundary_mode_o;
  wire [`PIN_GROUPS-1:0] pad_in_i, pad_out_o, pad_oe_o, core_pad_in_o;
  wire [31:0] debug_cfg_o, rd_data_o;
  always #4 clk_sys_i = ~clk_sys_i;
  // pad wire level: chip drive wins, else the board's level
  assign pad_in_i = (pad_oe_o & pad_out_o) | (~pad_oe_o & PAD);
  always @(posedge clk_sys_i) begin
    inject_cnt <= inject_cnt + {7'h00, store_multiple_injection_o === 1'b1};
    restart_cnt <= restart_cnt + {7'h00, core_restart_o === 1'b1};
  end
  debug_and_boundary_scan_port #(.CHIP_ID_VALUE(CHIP_ID), .CPU_ID_VALUE(CPU_ID)) DUT (.*);
  jtag_probe P (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o));
  // ****************************************
  // tasks
  // ****************************************
  task automatic cw(input string s, input logic [31:0] x, input logic [31:0] y);
    checks++;
    if (y !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic cv(input string s, input logic [191:0] x, input logic [191:0] y);
    checks++;
    if (y !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, x, y);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] x);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= x;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] x);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    x = rd_data_o;
  endtask
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #800000;
    bad_count++;
    close_out();
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    tick(10);
    reset_i <= 1'b0;
    tick(8);
    rd(`A_CHIP_ID, w);
    cw("chip id", CHIP_ID, w);
    wr(`A_CHIP_ID, 32'hffff_ffff);
    rd(`A_CHIP_ID, w);
    cw("chip id kept", CHIP_ID, w);
    rd(5'h14, w);
    cw("unmapped", 32'h0, w);
    factory_mode_pin_i <= 1'b1;
    tick(6);
    rd(`A_STATUS, w);
    cw("status", 32'h0000_0010, w);
    factory_mode_pin_i <= 1'b0;
    wr(`A_CTRL, 32'h0000_000e);
    tick(2);
    cv("irq and xfer", 192'h6, {tx_irq_o, xfer_rx_req_o, xfer_tx_req_o});
    serial_rx_ready_i <= 1'b0;
    serial_tx_empty_i <= 1'b1;
    wr(`A_COMM_TX, TX_W);
    tick(2);
    cv("flag irq xfer", 192'h9, {debug_channel_tx_flag_o, tx_irq_o, xfer_rx_req_o,
       xfer_tx_req_o});
    P.tap_reset();
    P.scan(1'b0, 32, 192'h0, v);
    cw("cpu id", CPU_ID, v[31:0]);
    core_halted_i <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      P.scan(1'b1, 4, `IR_SCAN_N, v);
      P.scan(1'b0, 4, 192'(c), v);
      P.scan(1'b1, 4, `IR_INTEST, v);
      P.scan(1'b0, 32, wc[c], v);
      if (c < 2) cw("chain capture", (c == 0) ? HALT_W : TX_W, v[31:0]);
    end
    tick(4);
    cv("inject rx irq", 192'h3, {inject_cnt, rx_irq_o});
    cw("cfg", wc[2], debug_cfg_o);
    rd(`A_COMM_RX, w);
    cw("comm rx", wc[1], w);
    rd(`A_STATUS, w);
    cw("status", 32'h0000_0020, w);
    P.scan(1'b1, 4, `IR_RESTART, v);
    P.tap_reset();
    tick(4);
    cv("restart", 192'h1, restart_cnt);
    wr(`A_CTRL, 32'h0000_0001);
    P.scan(1'b1, 4, `IR_SCAN_N, v);
    P.scan(1'b0, 33, 192'h5a5a_c3c3, v);
    cv("blocked", 192'h5a5a_c3c3 << 1, {v[32:1], v[0]});
    P.scan(1'b1, 4, `IR_IDCODE, v);
    P.scan(1'b0, 32, 192'h0, v);
    cw("cpu id blocked", CPU_ID, v[31:0]);
    scan_vs_emulator_select_i <= 1'b1;
    tick(10);
    rd(`A_STATUS, w);
    cv("mode held", 192'h1, {boundary_mode_o, w[`ST_MISMATCH]});
    chip_reset_pin_n_i <= 1'b0;
    tick(5);
    chip_reset_pin_n_i <= 1'b1;
    tick(12);
    cv("boundary mode", 192'h1, boundary_mode_o);
    P.tap_reset();
    P.scan(1'b0, 8, 192'ha5, v);
    cv("bypass", 192'h4a, v[7:0]);
    e = '0;
    d = '0;
    for (int g = 0; g < `PIN_GROUPS; g++) begin
      e[185 - 3 * g] = (COE[g] & COUT[g]) | (~COE[g] & PAD[g]);
      e[184 - 3 * g] = COUT[g];
      e[183 - 3 * g] = COE[g];
      d[184 - 3 * g] = XA[g];
      d[183 - 3 * g] = XB[g];
    end
    P.scan(1'b1, 4, `IR_SAMPLE, v);
    P.scan(1'b0, 192, 192'h2d, v);
    cv("sample chain", e, {6'h00, v[185:0]});
    cv("chain length", 192'h2d, v[191:186]);
    P.scan(1'b1, 4, `IR_EXTEST, v);
    P.scan(1'b0, 186, d, v);
    tick(4);
    cv("pad oe", XB, pad_oe_o);
    cv("pad out", XA & XB, pad_out_o & XB);
    cv("core pad in", (XA & XB) | (~XB & PAD), core_pad_in_o);
    close_out();
  end
endmodule
`default_nettype wire
